// ---- verilog/csc_ctrl.sv ----
// clock synthesizer control register with axi4-lite slave and loss handling
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module csc_ctrl #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // clock module side
   input  wire logic              pll_lock,
   input  wire logic              clock_loss_status,
   input  wire logic              clock_loss_flag,
   input  wire logic              pll_clock_mode,
   input  wire logic              stop_pll_off,
   input  wire logic              core_clk_fall,
   input  wire logic [2:0]        multiplier_code,
   output logic [2:0]             post_divider_code,
   output logic [4:0]             sys_freq_mult,
   output logic                   clock_loss_detect_en,
   output logic                   lock_loss_reset_req,
   output logic                   clock_loss_reset_req,
   output logic                   lock_loss_irq_req,
   output logic                   clock_loss_irq_req,
   output logic                   clock_output_disable,
   output logic                   fm_rate,
   output logic [1:0]             fm_depth,
   output logic [9:0]             expected_difference,
   output logic                   fm_enable,
   output logic                   fm_cal_start
);
   import csc_pkg::*;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // feedback multiplication 2*(m+2)
   function automatic logic [4:0] fb_mult(input logic [2:0] m);
      return {1'b0, m, 1'b0} + 5'h04;
   endfunction

   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [31:0]       off);
      return a == off[ADDR_W-1:0];
   endfunction

   csc_ctrl_t   ctrl;
   logic [2:0]  div_active;
   logic        lock_s1;
   logic        lock_s2;
   logic        lock_s3;
   logic        lock_q;

   // write channel holding registers
   logic              aw_held;
   logic [ADDR_W-1:0] aw_addr;
   logic              w_held;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;

   // lock comes from the analog loop, so it is filtered across three stages
   // a lock glitch shorter than two cycles never reaches the loss logic
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
         lock_s3 <= 1'b0;
         lock_q  <= 1'b0;
      end else begin
         lock_s1 <= pll_lock;
         lock_s2 <= lock_s1;
         lock_s3 <= lock_s2;
         if (lock_s2 == lock_s3) begin
            lock_q <= lock_s3;
         end
      end
   end

   // ---------------- write path ----------------
   wire       aw_take   = s_axi_awvalid && s_axi_awready;
   wire       w_take    = s_axi_wvalid && s_axi_wready;
   wire       have_aw   = aw_held || aw_take;
   wire       have_w    = w_held || w_take;
   wire       wr_fire   = have_aw && have_w && !s_axi_bvalid;
   wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
   wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;

   wire       wr_ctrl   = wr_fire && addr_is(wr_addr, CSC_CTRL_OFFSET);
   wire       wr_status = wr_fire && addr_is(wr_addr, CSC_STATUS_OFFSET);
   wire       wr_ok     = wr_ctrl || wr_status;

   wire csc_ctrl_t next_ctrl_raw = merge_bytes(ctrl, wr_data, wr_strb);
   csc_ctrl_t next_ctrl;
   assign next_ctrl = {10'h000, next_ctrl_raw[21:0]};

   // either lane of the expected difference counts as a write of that field
   wire       exp_written  = wr_ctrl && (wr_strb[0] || wr_strb[1]);
   wire       rate_changed = wr_ctrl && (next_ctrl.fm_rate != ctrl.fm_rate);
   // reserved depth code still counts as nonzero and turns modulation on
   wire       depth_on     = next_ctrl.fm_depth != CSC_DEPTH_NONE;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (aw_take) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (w_take) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
   end

   // ready drops once an item is held, so each channel stalls until the response
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !have_aw && !wr_fire && !(s_axi_bvalid && !s_axi_bready);
         s_axi_wready  <= !have_w && !wr_fire && !(s_axi_bvalid && !s_axi_bready);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= CSC_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- control register ----------------
   // status word is read-only; a write there is accepted and dropped
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= CSC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= next_ctrl;
      end
   end

   // modulation enable follows depth, and any expected-difference write forces it on
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fm_enable    <= 1'b0;
         fm_cal_start <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            fm_enable <= depth_on || exp_written;
         end
         fm_cal_start <= rate_changed;
      end
   end

   // divider swap waits for the core clock falling edge; the loop is untouched
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_active <= CSC_DIV_RESET;
      end else if (core_clk_fall) begin
         div_active <= ctrl.post_divider_code;
      end
   end

   // ---------------- loss handling ----------------
   wire pll_on      = pll_clock_mode;
   wire det_on      = pll_on && ctrl.clock_loss_detect_en;
   // stop with the loop off looks like a lost clock to the detector
   wire clk_lost    = clock_loss_status || stop_pll_off;
   wire lock_lost   = !lock_q;

   wire next_ll_rst = pll_on && ctrl.lock_loss_reset_en && lock_lost;
   wire next_cl_rst = det_on && ctrl.clock_loss_reset_en && clk_lost;
   wire next_ll_irq = pll_on && ctrl.lock_loss_irq_en && lock_lost;
   wire next_cl_irq = det_on && ctrl.clock_loss_irq_en && clock_loss_flag;
   // external mode reports divide-by-one; the stored code waits for pll mode
   wire [2:0] next_div = pll_on ? div_active : CSC_DIV_RESET;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lock_loss_reset_req  <= 1'b0;
         clock_loss_reset_req <= 1'b0;
         lock_loss_irq_req    <= 1'b0;
         clock_loss_irq_req   <= 1'b0;
         clock_loss_detect_en <= 1'b0;
         post_divider_code    <= CSC_DIV_RESET;
         sys_freq_mult        <= 5'h04;
      end else begin
         lock_loss_reset_req  <= next_ll_rst;
         clock_loss_reset_req <= next_cl_rst;
         lock_loss_irq_req    <= next_ll_irq;
         clock_loss_irq_req   <= next_cl_irq;
         clock_loss_detect_en <= det_on;
         post_divider_code    <= next_div;
         sys_freq_mult        <= fb_mult(multiplier_code);
      end
   end

   // field outputs registered once more so every output leaves a flip-flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clock_output_disable <= 1'b0;
         fm_rate              <= 1'b0;
         fm_depth             <= CSC_DEPTH_NONE;
         expected_difference  <= 10'h000;
      end else begin
         clock_output_disable <= ctrl.clock_output_disable;
         fm_rate              <= ctrl.fm_rate;
         fm_depth             <= ctrl.fm_depth;
         expected_difference  <= ctrl.expected_difference;
      end
   end

   // ---------------- read path ----------------
   // one read in flight; arready stays low until the data is taken
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire rd_ctrl = addr_is(s_axi_araddr, CSC_CTRL_OFFSET);
   wire rd_stat = addr_is(s_axi_araddr, CSC_STATUS_OFFSET);

   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[CSC_ST_DIV_LSB +: 3] = div_active;
      status_word[CSC_ST_FM_BIT]       = fm_enable;
      status_word[CSC_ST_MODE_BIT]     = pll_on;
      status_word[CSC_ST_FLAG_BIT]     = clock_loss_flag;
      status_word[CSC_ST_LOSS_BIT]     = clock_loss_status;
      status_word[CSC_ST_LOCK_BIT]     = lock_q;
   end

   wire [31:0] rd_word = rd_ctrl ? ctrl : (rd_stat ? status_word : 32'h0000_0000);
   wire [1:0]  rd_resp = (rd_ctrl || rd_stat) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !rd_take && !(s_axi_rvalid && !s_axi_rready);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= CSC_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ---- verilog/csc_pkg.sv ----
// constants, field layout and types of the clock synthesizer control block
// Overview of operation
// - bits 21-19 set system clock post-divisor; changing it never disturbs the PLL
// - a new post-divider takes effect at the next core clock falling edge
// - external clock mode ignores divider, detect enable, reset and interrupt enables
// - bit 18 enables clock loss detection; lock loss detection is unaffected
// - bit 17 set resets the system on lock loss; clear ignores it
// - lock loss reset enable set while unlocked resets at once in PLL modes
// - bit 16 resets on clock loss; ignored while detection is disabled
// - clock loss reset enable set during a present clock loss resets at once
// - bit 15 set disables the clock output pin and holds it low
// - bit 14 requests lock loss interrupt; set while unlocked requests at once
// - bit 13 requests clock loss interrupt when enabled and flag set
// - bit 12 selects modulation rate; writing a changed value starts calibration
// - bits 11-10 set modulation depth; nonzero enables frequency modulation
// - bits 9-0 hold expected difference; writing them enables frequency modulation
// - system frequency is reference times 2(multiplier+2) over 2^post-divider
package csc_pkg;

   localparam logic [31:0] CSC_CTRL_OFFSET   = 32'h0000_0000;
   localparam logic [31:0] CSC_STATUS_OFFSET = 32'h0000_0004;

   // control field positions
   localparam int CSC_DIV_LSB   = 19;
   localparam int CSC_DET_BIT   = 18;
   localparam int CSC_LLRE_BIT  = 17;
   localparam int CSC_CLRE_BIT  = 16;
   localparam int CSC_DIS_BIT   = 15;
   localparam int CSC_LLIRQ_BIT = 14;
   localparam int CSC_CLIRQ_BIT = 13;
   localparam int CSC_RATE_BIT  = 12;
   localparam int CSC_DEPTH_LSB = 10;
   localparam int CSC_EXP_LSB   = 0;

   // status field positions
   localparam int CSC_ST_DIV_LSB  = 0;
   localparam int CSC_ST_FM_BIT   = 3;
   localparam int CSC_ST_MODE_BIT = 4;
   localparam int CSC_ST_FLAG_BIT = 5;
   localparam int CSC_ST_LOSS_BIT = 6;
   localparam int CSC_ST_LOCK_BIT = 7;

   localparam logic [1:0] CSC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CSC_RESP_SLVERR = 2'h2;

   localparam logic [2:0] CSC_DIV_RESET   = 3'h0;
   localparam logic [1:0] CSC_DEPTH_NONE  = 2'h0;

   typedef struct packed {
      logic [9:0] reserved_hi;
      logic [2:0] post_divider_code;
      logic       clock_loss_detect_en;
      logic       lock_loss_reset_en;
      logic       clock_loss_reset_en;
      logic       clock_output_disable;
      logic       lock_loss_irq_en;
      logic       clock_loss_irq_en;
      logic       fm_rate;
      logic [1:0] fm_depth;
      logic [9:0] expected_difference;
   } csc_ctrl_t;

   localparam csc_ctrl_t CSC_CTRL_RESET = 32'h0000_0000;

endpackage

// ---- test/csc_ctrl_assertions.sv ----
// port-level checks of the clock synthesizer control block
`timescale 1ns/1ns
module csc_ctrl_assertions (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        pll_lock,
   input wire logic        pll_clock_mode,
   input wire logic        clock_loss_status,
   input wire logic        clock_loss_flag,
   input wire logic        stop_pll_off,
   input wire logic        core_clk_fall,
   input wire logic [2:0]  multiplier_code,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [2:0]  post_divider_code,
   input wire logic [4:0]  sys_freq_mult,
   input wire logic        clock_loss_detect_en,
   input wire logic        lock_loss_reset_req,
   input wire logic        clock_loss_reset_req,
   input wire logic        lock_loss_irq_req,
   input wire logic        clock_loss_irq_req,
   input wire logic [1:0]  fm_depth,
   input wire logic        fm_enable,
   input wire logic        fm_cal_start
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_ext_quiet: assert property (!pll_clock_mode |=> post_divider_code == 3'h0
      && !clock_loss_detect_en && !(lock_loss_reset_req | clock_loss_reset_req
      | lock_loss_irq_req | clock_loss_irq_req)) else $error("external mode not ignored");
   a_lockreq_mode: assert property ((lock_loss_reset_req | lock_loss_irq_req)
      |-> $past(pll_clock_mode)) else $error("lock loss request outside pll mode");
   a_lossrst_det: assert property (clock_loss_reset_req |-> clock_loss_detect_en)
      else $error("clock loss reset while detection off");
   a_lossrst_src: assert property (clock_loss_reset_req
      |-> $past(clock_loss_status | stop_pll_off)) else $error("clock loss reset without cause");
   a_lossirq_src: assert property (clock_loss_irq_req
      |-> clock_loss_detect_en && $past(clock_loss_flag)) else $error("clock loss irq without cause");
   a_div_on_fall: assert property (pll_clock_mode && $past(pll_clock_mode)
      && $past(pll_clock_mode, 2) && $changed(post_divider_code)
      |-> $past(core_clk_fall) || $past(core_clk_fall, 2)) else $error("divider moved off a fall");
   a_freq_mult: assert property ($past(resetn)
      |-> sys_freq_mult == 5'(2 * ($past(multiplier_code) + 2))) else $error("wrong multiplier");
   a_cal_pulse: assert property (fm_cal_start |-> s_axi_bvalid ##1 !fm_cal_start)
      else $error("calibration start not a write pulse");
   a_depth_fm: assert property (fm_depth != 2'h0 |-> $past(fm_enable))
      else $error("depth set without modulation");
   a_rsv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:22] == 10'h000)
      else $error("reserved bits read nonzero");
endmodule

bind csc_ctrl csc_ctrl_assertions u_chk (
   .clk                  (clk),
   .resetn               (resetn),
   .pll_lock             (pll_lock),
   .pll_clock_mode       (pll_clock_mode),
   .clock_loss_status    (clock_loss_status),
   .clock_loss_flag      (clock_loss_flag),
   .stop_pll_off         (stop_pll_off),
   .core_clk_fall        (core_clk_fall),
   .multiplier_code      (multiplier_code),
   .s_axi_bvalid         (s_axi_bvalid),
   .s_axi_rvalid         (s_axi_rvalid),
   .s_axi_rdata          (s_axi_rdata),
   .post_divider_code    (post_divider_code),
   .sys_freq_mult        (sys_freq_mult),
   .clock_loss_detect_en (clock_loss_detect_en),
   .lock_loss_reset_req  (lock_loss_reset_req),
   .clock_loss_reset_req (clock_loss_reset_req),
   .lock_loss_irq_req    (lock_loss_irq_req),
   .clock_loss_irq_req   (clock_loss_irq_req),
   .fm_depth             (fm_depth),
   .fm_enable            (fm_enable),
   .fm_cal_start         (fm_cal_start)
);

// ---- test/tb.sv ----
// self-checking bench for the clock synthesizer control block
`timescale 1ns/1ns
module tb;
   import csc_pkg::*;
   logic        clk = 1'h0, resetn = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, core_clk_fall = 1'h0;
   logic        pll_lock = 1'h1, pll_clock_mode = 1'h1, stop_pll_off = 1'h0;
   logic        clock_loss_status = 1'h0, clock_loss_flag = 1'h0;
   logic [2:0]  multiplier_code = 3'h0, post_divider_code;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, fm_depth;
   logic [31:0] s_axi_rdata;
   logic [4:0]  sys_freq_mult;
   logic [9:0]  expected_difference;
   logic        clock_loss_detect_en, lock_loss_reset_req, clock_loss_reset_req;
   logic        lock_loss_irq_req, clock_loss_irq_req, clock_output_disable;
   logic        fm_rate, fm_enable, fm_cal_start;
   int          err_count = 0, cmp_count = 0, cal_cnt = 0, c0;
   // written word beside the word that should read back; depth passes zero between settings
   logic [63:0] rows [4] = '{{32'hFFFF_FFFF, 32'h003F_FFFF}, {32'h0000_8000, 32'h0000_8000},
                             {32'hC005_5AAA, 32'h0005_5AAA}, {32'h0000_0000, 32'h0000_0000}};

   csc_ctrl i_dut (
      .clk                  (clk),
      .resetn               (resetn),
      .s_axi_awaddr         (s_axi_awaddr),
      .s_axi_awvalid        (s_axi_awvalid),
      .s_axi_awready        (s_axi_awready),
      .s_axi_wdata          (s_axi_wdata),
      .s_axi_wstrb          (s_axi_wstrb),
      .s_axi_wvalid         (s_axi_wvalid),
      .s_axi_wready         (s_axi_wready),
      .s_axi_bresp          (s_axi_bresp),
      .s_axi_bvalid         (s_axi_bvalid),
      .s_axi_bready         (s_axi_bready),
      .s_axi_araddr         (s_axi_araddr),
      .s_axi_arvalid        (s_axi_arvalid),
      .s_axi_arready        (s_axi_arready),
      .s_axi_rdata          (s_axi_rdata),
      .s_axi_rresp          (s_axi_rresp),
      .s_axi_rvalid         (s_axi_rvalid),
      .s_axi_rready         (s_axi_rready),
      .pll_lock             (pll_lock),
      .clock_loss_status    (clock_loss_status),
      .clock_loss_flag      (clock_loss_flag),
      .pll_clock_mode       (pll_clock_mode),
      .stop_pll_off         (stop_pll_off),
      .core_clk_fall        (core_clk_fall),
      .multiplier_code      (multiplier_code),
      .post_divider_code    (post_divider_code),
      .sys_freq_mult        (sys_freq_mult),
      .clock_loss_detect_en (clock_loss_detect_en),
      .lock_loss_reset_req  (lock_loss_reset_req),
      .clock_loss_reset_req (clock_loss_reset_req),
      .lock_loss_irq_req    (lock_loss_irq_req),
      .clock_loss_irq_req   (clock_loss_irq_req),
      .clock_output_disable (clock_output_disable),
      .fm_rate              (fm_rate),
      .fm_depth             (fm_depth),
      .expected_difference  (expected_difference),
      .fm_enable            (fm_enable),
      .fm_cal_start         (fm_cal_start)
   );

   always #2 clk = ~clk;
   always @(posedge clk) if (fm_cal_start === 1'h1) cal_cnt <= cal_cnt + 1;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s,
                     input logic [1:0] er);
      bit fa, fw;
      fa = 0;
      fw = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dv;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // address and data may be taken at different edges
      while (!(fa && fw)) begin
         @(posedge clk);
         fa |= (s_axi_awready === 1'h1);
         fw |= (s_axi_wready === 1'h1);
         if (fa) s_axi_awvalid <= 1'h0;
         if (fw) s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1) @(posedge clk);
      chk("bresp", er, s_axi_bresp);
      s_axi_bready <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (s_axi_rvalid !== 1'h1);
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
      s_axi_rready <= 1'h0;
   endtask

   // outputs trail the register by one cycle, the lock filter by four more
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic rst;
      @(posedge clk);
      resetn <= 1'h0;
      repeat (3) @(posedge clk);
      resetn <= 1'h1;
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      print_verdict();
   end

   initial begin
      rst();
      rd(8'h00, 32'h0, CSC_RESP_OKAY);
      chk("fm_enable", 0, fm_enable);
      wr(8'h00, 32'hFFFF_FFFF, 4'h4, CSC_RESP_OKAY);
      settle();
      rd(8'h00, 32'h003F_0000, CSC_RESP_OKAY);
      chk("fm_enable", 0, fm_enable);
      wr(8'h00, 32'h0000_0001, 4'h1, CSC_RESP_OKAY);
      settle();
      chk("fm_enable", 1, fm_enable);
      $display("test strobes done");
      foreach (rows[i]) begin
         wr(8'h00, rows[i][63:32], 4'hF, CSC_RESP_OKAY);
         rd(8'h00, rows[i][31:0], CSC_RESP_OKAY);
         settle();
         chk("fields", {rows[i][15], rows[i][12:0], rows[i][18]}, {clock_output_disable, fm_rate,
             fm_depth, expected_difference, clock_loss_detect_en});
      end
      $display("test table done");
      wr(8'h00, 32'h0028_0000, 4'hF, CSC_RESP_OKAY);
      settle();
      chk("divider", 0, post_divider_code);
      @(posedge clk);
      core_clk_fall <= 1'h1;
      @(posedge clk);
      core_clk_fall <= 1'h0;
      settle();
      chk("divider", 5, post_divider_code);
      rd(8'h04, 32'h0000_009D, CSC_RESP_OKAY);
      for (int m = 0; m < 8; m++) begin
         @(posedge clk);
         multiplier_code <= 3'(m);
         settle();
         chk("freq_mult", 2 * (m + 2), sys_freq_mult);
      end
      $display("test divider done");
      @(posedge clk);
      pll_lock <= 1'h0;
      settle();
      chk("lock_req", 0, {lock_loss_reset_req, lock_loss_irq_req});
      wr(8'h00, 32'h0002_4000, 4'hF, CSC_RESP_OKAY);
      settle();
      chk("lock_req", 3, {lock_loss_reset_req, lock_loss_irq_req});
      @(posedge clk);
      pll_lock <= 1'h1;
      settle();
      chk("lock_req", 0, {lock_loss_reset_req, lock_loss_irq_req});
      $display("test lock loss done");
      @(posedge clk);
      clock_loss_status <= 1'h1;
      clock_loss_flag <= 1'h1;
      wr(8'h00, 32'h0005_2000, 4'hF, CSC_RESP_OKAY);
      settle();
      chk("loss", 7, {clock_loss_reset_req, clock_loss_irq_req, clock_loss_detect_en});
      wr(8'h00, 32'h0001_2000, 4'hF, CSC_RESP_OKAY);
      settle();
      chk("loss", 0, {clock_loss_reset_req, clock_loss_irq_req, clock_loss_detect_en});
      @(posedge clk);
      clock_loss_status <= 1'h0;
      clock_loss_flag <= 1'h0;
      stop_pll_off <= 1'h1;
      wr(8'h00, 32'h0005_0000, 4'hF, CSC_RESP_OKAY);
      settle();
      chk("loss", 5, {clock_loss_reset_req, clock_loss_irq_req, clock_loss_detect_en});
      @(posedge clk);
      stop_pll_off <= 1'h0;
      pll_clock_mode <= 1'h0;
      pll_lock <= 1'h0;
      clock_loss_status <= 1'h1;
      clock_loss_flag <= 1'h1;
      wr(8'h00, 32'h007F_6000, 4'hF, CSC_RESP_OKAY);
      settle();
      chk("ext", 0, {post_divider_code, clock_loss_detect_en, lock_loss_reset_req,
          clock_loss_reset_req, lock_loss_irq_req, clock_loss_irq_req});
      rd(8'h00, 32'h003F_6000, CSC_RESP_OKAY);
      wr(8'h00, 32'h0, 4'hF, CSC_RESP_OKAY);
      @(posedge clk);
      pll_clock_mode <= 1'h1;
      pll_lock <= 1'h1;
      clock_loss_status <= 1'h0;
      clock_loss_flag <= 1'h0;
      $display("test clock loss done");
      c0 = cal_cnt;
      repeat (2) begin
         wr(8'h00, 32'h0000_1000, 4'hF, CSC_RESP_OKAY);
         settle();
         chk("cal_starts", c0 + 1, cal_cnt);
      end
      rd(8'h10, 32'h0, CSC_RESP_SLVERR);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF, CSC_RESP_SLVERR);
      wr(8'h04, 32'hFFFF_FFFF, 4'hF, CSC_RESP_OKAY);
      rd(8'h00, 32'h0000_1000, CSC_RESP_OKAY);
      $display("test calibration and bus done");
      rst();
      rd(8'h00, 32'h0, CSC_RESP_OKAY);
      chk("fm_enable", 0, fm_enable);
      $display("test second reset done");
      print_verdict();
   end
endmodule
